// [dv/fasd_cmd_src.sv]
// Command decoder model that feeds bank writes and command addresses.
// Assumes the bench clock; every request is driven after a falling edge.
`timescale 1ns/10ps
module fasd_cmd_src (
  input  wire logic                        clk_sys,
  output logic                             bar_wr,
  output logic [fasd_pkg::BAR_W-1:0]       bar_wr_data,
  output logic                             cmd_valid,
  output logic [fasd_pkg::ADDR_W-1:0]      cmd_addr,
  output logic                             cmd_legacy,
  output logic                             cmd_main
);
  // Quiet at start so nothing is taken while reset is high
  initial begin
    bar_wr      = 1'b0;
    bar_wr_data = 8'h00;
    cmd_valid   = 1'b0;
    cmd_addr    = 32'h0000_0000;
    cmd_legacy  = 1'b0;
    cmd_main    = 1'b0;
  end

  // One cycle of request; unqualified fields are scrambled, not held
  task automatic drive(input logic bw, input logic [7:0] bd,
                       input logic cv, input logic [31:0] a,
                       input logic leg, input logic mn);
    @(negedge clk_sys);
    bar_wr      = bw;
    bar_wr_data = bw ? bd : ~bar_wr_data;
    cmd_valid   = cv;
    cmd_addr    = cv ? a : ~cmd_addr;
    cmd_legacy  = cv ? leg : ~cmd_legacy;
    cmd_main    = cv ? mn : ~cmd_main;
  endtask
endmodule

// [dv/tb_flash_address_sector_decoder.sv]
// Self-checking bench: six model variants share one command source.
// Assumes variants 0..2 are 256 Mbit and 3..5 are 128 Mbit parts.
`timescale 1ns/10ps
module tb_flash_address_sector_decoder;
  localparam int NV = 6;           // Bottom, top, uniform per size
  logic        clk_sys = 1'b0;     // 200 MHz system clock
  logic        reset   = 1'b1;     // Synchronous, active high
  logic        bar_wr;
  logic [7:0]  bar_wr_data;
  logic        cmd_valid;
  logic [31:0] cmd_addr;
  logic        cmd_legacy;
  logic        cmd_main;
  logic [7:0]  bar_o    [NV];
  logic        addr32_o [NV];
  logic        ov_o     [NV];
  logic [31:0] eff_o    [NV];
  logic        main_o   [NV];
  logic [9:0]  sec_o    [NV];
  logic        prm_o    [NV];
  logic [42:0] exp_r    [NV];      // Expected eff, sector, small flag
  logic [7:0]  bar_m    = 8'h00;   // Bench copy of the bank register
  logic        exp_v    = 1'b0;
  logic        exp_main = 1'b0;
  int          fails    = 0;
  int          check_count = 0;
  int          cycles   = 0;
  // Boundaries of small and large sectors, with junk in the top byte
  logic [31:0] corner [6] = '{32'hAB01_F123, 32'h0001_FFFF,
    32'h0002_0000, 32'h5AFF_FFFF, 32'h01FE_0000, 32'h01FF_F000};
  logic [7:0]  banks  [4] = '{8'h00, 8'h01, 8'h81, 8'h7F};

  always #2.5 clk_sys = ~clk_sys;

  fasd_cmd_src src (.clk_sys(clk_sys), .bar_wr(bar_wr),
    .bar_wr_data(bar_wr_data), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_legacy(cmd_legacy), .cmd_main(cmd_main));

  for (genvar i = 0; i < NV; i++) begin : g
    fasd_top #(
      .ARRAY_AW((i < 3) ? 25 : 24),
      .LAYOUT  (fasd_pkg::fasd_layout_t'(i % 3))
    ) dut (.clk_sys(clk_sys), .reset(reset), .bar_wr(bar_wr),
      .bar_wr_data(bar_wr_data), .cmd_valid(cmd_valid),
      .cmd_addr(cmd_addr), .cmd_legacy(cmd_legacy), .cmd_main(cmd_main),
      .bar_q(bar_o[i]), .addr32_q(addr32_o[i]), .out_valid_q(ov_o[i]),
      .eff_addr_q(eff_o[i]), .main_q(main_o[i]), .sector_q(sec_o[i]),
      .param_q(prm_o[i]));
  end

  // Effective address, sector index and small flag for one variant
  function automatic logic [42:0] expect_of(input logic [31:0] a,
      input logic leg, input logic mn, input logic [7:0] bk, input int v);
    logic [31:0] e;
    logic [31:0] m;
    logic [31:0] top;
    e = (mn && leg && !bk[7]) ? {1'b0, bk[6:0], a[23:0]} : a;
    if (mn && v >= 3) e[31:24] = 8'h00;
    top = (v < 3) ? 32'h0200_0000 : 32'h0100_0000;
    m = e & (top - 32'h0000_0001);
    if (!mn) return {e, 10'h000, 1'b0};
    if (v % 3 == 2) return {e, 10'(m >> 18), 1'b0};
    if (v % 3 == 0 && m < 32'h0002_0000) return {e, 10'(m >> 12), 1'b1};
    if (v % 3 == 0) return {e, 10'((m >> 16) + 30), 1'b0};
    if (m >= top - 32'h0002_0000) begin
      return {e, 10'((top >> 16) - 2 + ((m >> 12) & 31)), 1'b1};
    end
    return {e, 10'(m >> 16), 1'b0};
  endfunction

  // One comparison, counted; a mismatch reports at once
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Golden model samples at the edge where the design takes requests
  always @(posedge clk_sys) begin
    exp_v <= cmd_valid && !reset;
    // Reset clears the held result word as well
    if (reset) begin
      exp_main <= 1'b0;
      for (int i = 0; i < NV; i++) begin
        exp_r[i] <= '0;
      end
    end else if (cmd_valid) begin
      exp_main <= cmd_main;
      for (int i = 0; i < NV; i++) begin
        exp_r[i] <= expect_of(cmd_addr, cmd_legacy, cmd_main, bar_m, i);
      end
    end
    // Old bank value still seen by a command in the same cycle
    if (reset) bar_m <= 8'h00;
    else if (bar_wr) bar_m <= bar_wr_data;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end

  // Outputs are settled by the falling edge
  always @(negedge clk_sys) begin
    for (int i = 0; i < NV; i++) begin
      chk("bar_q", 32'(bar_m), 32'(bar_o[i]));
      chk("addr32_q", 32'(bar_m[7]), 32'(addr32_o[i]));
      chk("out_valid_q", 32'(exp_v), 32'(ov_o[i]));
      // Result word checked every cycle, so holding is checked too
      chk("eff_addr_q", exp_r[i][42:11], eff_o[i]);
      chk("main_q", 32'(exp_main), 32'(main_o[i]));
      chk("sector_q", 32'(exp_r[i][10:1]), 32'(sec_o[i]));
      chk("param_q", 32'(exp_r[i][0]), 32'(prm_o[i]));
    end
  end

  initial begin
    void'($urandom(36));
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    // Every bank value, legacy and new, main and separate, back to back
    foreach (banks[b]) begin
      src.drive(1'b1, banks[b], 1'b1, corner[b], 1'b1, 1'b1);
      foreach (corner[k]) begin
        for (int m = 0; m < 4; m++) begin
          src.drive(1'b0, 8'h00, 1'b1, corner[k], m[0], m[1]);
        end
      end
    end
    // Bank load alone, then a legacy command that must pick it up
    foreach (banks[b]) begin
      src.drive(1'b1, banks[b], 1'b0, 32'h0000_0000, 1'b0, 1'b0);
      src.drive(1'b0, 8'h00, 1'b1, corner[b], 1'b1, 1'b1);
    end
    $display("Test corner sweep done");
    repeat (400) begin
      src.drive(($urandom % 8) == 0, 8'($urandom), ($urandom % 4) != 0,
                $urandom, 1'($urandom), 1'($urandom));
    end
    $display("Test random traffic done");
    // Reset in mid-run must drop extended mode and bank bits
    src.drive(1'b1, 8'h81, 1'b1, 32'h0123_4567, 1'b1, 1'b1);
    src.drive(1'b0, 8'h00, 1'b0, 32'h0000_0000, 1'b0, 1'b0);
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    src.drive(1'b0, 8'h00, 1'b1, 32'hFF01_F000, 1'b1, 1'b1);
    src.drive(1'b0, 8'h00, 1'b0, 32'h0000_0000, 1'b0, 1'b0);
    repeat (3) @(negedge clk_sys);
    $display("Test reset recovery done");
    give_verdict();
  end
endmodule

// [logic/fasd_pkg.sv]
// Shared constants for the flash address and sector decoder.
// Assumes a single clock domain; no tool-specific constructs.
package fasd_pkg;

  // Address widths
  localparam int ADDR_W   = 32;           // Full command address
  localparam int LEG_AW   = 24;           // Legacy address field
  localparam int AW_128   = 24;           // Main array, 128 Mbit part
  localparam int AW_256   = 25;           // Main array, 256 Mbit part

  // Bank address register layout
  localparam int        BAR_W   = 8;      // Register width
  localparam int        EXT_BIT = 7;      // Extended-address mode bit
  localparam int        BANK_W  = 7;      // High address bits supplied
  localparam logic [7:0] BAR_RST = 8'h00; // Value after reset

  // Sector geometry, as bit positions of the byte address
  localparam int PSEC_LSB = 12;           // 4 kB parameter sector
  localparam int S64_LSB  = 16;           // 64 kB sector
  localparam int PREG_LSB = 17;           // 128 kB parameter region
  localparam int UNI_LSB  = 18;           // 256 kB uniform sector
  localparam int PSEC_CNT = 32;           // Parameter sector count
  localparam int SECT_W   = 10;           // Sector index width

  // Sector layout, fixed per device model
  typedef enum logic [1:0] {
    LAY_BOTTOM,
    LAY_TOP,
    LAY_UNIFORM
  } fasd_layout_t;

endpackage

// [logic/fasd_sector_map.sv]
// Combinational map from array byte address to erase sector.
// Assumes the caller registers the result; address is the main array.
`timescale 1ns/10ps
module fasd_sector_map #(
  parameter int                   AW     = fasd_pkg::AW_256,
  parameter fasd_pkg::fasd_layout_t LAYOUT = fasd_pkg::LAY_BOTTOM
) (
  input  wire logic [AW-1:0]               addr,
  output logic      [fasd_pkg::SECT_W-1:0] sector,
  output logic                             param
);

  // 64 kB sectors left beside the parameter region: 510 or 254
  localparam int N64 = (1 << (AW - fasd_pkg::S64_LSB)) - 2;
  // Index offset of 64 kB sectors above a bottom parameter region
  localparam int BOT_OFS = fasd_pkg::PSEC_CNT - 2;

  // The map needs room above 256 kB and an index wide enough
  localparam bit AW_OK = (AW > fasd_pkg::UNI_LSB) &&
      ((1 << (AW - fasd_pkg::S64_LSB)) + fasd_pkg::PSEC_CNT - 2 <=
       (1 << fasd_pkg::SECT_W));
  if (!AW_OK) begin : g_bad_aw
    $error("fasd_sector_map: AW out of range");
  end

  // Index of a 4 kB sector inside the parameter region
  function automatic logic [fasd_pkg::SECT_W-1:0] psec(
    input logic [AW-1:0] a);
    psec = fasd_pkg::SECT_W'(a[fasd_pkg::PREG_LSB-1:fasd_pkg::PSEC_LSB]);
  endfunction

  // Index of a 64 kB sector counted from address zero
  function automatic logic [fasd_pkg::SECT_W-1:0] s64(
    input logic [AW-1:0] a);
    s64 = fasd_pkg::SECT_W'(a[AW-1:fasd_pkg::S64_LSB]);
  endfunction

  // Layout is a model constant, so only one branch survives synthesis
  always_comb begin
    sector = '0;
    param  = 1'b0;
    unique case (LAYOUT)
      fasd_pkg::LAY_BOTTOM: begin
        // Lowest 128 kB split into 4 kB sectors
        if (addr[AW-1:fasd_pkg::PREG_LSB] == '0) begin
          param  = 1'b1;
          sector = psec(addr);
        end else begin
          sector = s64(addr) + fasd_pkg::SECT_W'(BOT_OFS);
        end
      end
      fasd_pkg::LAY_TOP: begin
        // Highest 128 kB split into 4 kB sectors
        if (&addr[AW-1:fasd_pkg::PREG_LSB]) begin
          param  = 1'b1;
          sector = fasd_pkg::SECT_W'(N64) + psec(addr);
        end else begin
          sector = s64(addr);
        end
      end
      fasd_pkg::LAY_UNIFORM: begin
        // Plain 256 kB blocks from zero
        sector = fasd_pkg::SECT_W'(addr[AW-1:fasd_pkg::UNI_LSB]);
      end
    endcase
  end

endmodule

// [logic/fasd_top.sv]
// Address former and sector decoder of a serial NOR flash.
// Assumes the command decoder runs on clk_sys and hands over one
// decoded address per cmd_valid pulse; the array sits downstream.
//
// How it works
// - Legacy 24-bit address takes bank high bits
// - Extended mode: legacy commands use 32 bits
// - New commands use full 32 bits, except in the small part's main array
// - Reset clears bank register and extended mode
// - Small part drops bits 31..24 for array
// - Separate spaces use the full 32-bit address
// - Bottom layout: 32 small sectors, then 64k
// - Top layout: 64k sectors, 32 small on top
// - Uniform layout: 256 kB sectors from zero
// - Layout fixed by model, sector is erase unit
// - Small part: 254 large or 64 uniform
`timescale 1ns/10ps
module fasd_top #(
  parameter int                     ARRAY_AW = fasd_pkg::AW_256,
  parameter fasd_pkg::fasd_layout_t LAYOUT   = fasd_pkg::LAY_BOTTOM
) (
  input  wire logic                             clk_sys,
  input  wire logic                             reset,
  input  wire logic                             bar_wr,
  input  wire logic [fasd_pkg::BAR_W-1:0]       bar_wr_data,
  input  wire logic                             cmd_valid,
  input  wire logic [fasd_pkg::ADDR_W-1:0]      cmd_addr,
  input  wire logic                             cmd_legacy,
  input  wire logic                             cmd_main,
  output logic      [fasd_pkg::BAR_W-1:0]       bar_q,
  output logic                                  addr32_q,
  output logic                                  out_valid_q,
  output logic      [fasd_pkg::ADDR_W-1:0]      eff_addr_q,
  output logic                                  main_q,
  output logic      [fasd_pkg::SECT_W-1:0]      sector_q,
  output logic                                  param_q
);

  // Only the two documented densities have a sector map
  localparam bit AW_OK = (ARRAY_AW == fasd_pkg::AW_128) ||
                         (ARRAY_AW == fasd_pkg::AW_256);
  // Refuse any other width at elaboration, not at run time
  if (!AW_OK) begin : g_bad_aw
    $error("fasd_top: ARRAY_AW must be 24 or 25");
  end

  // True for the 128 Mbit model
  localparam bit SMALL = (ARRAY_AW == fasd_pkg::AW_128);
  // Total sectors for this model, used as an upper bound
  localparam int NSECT = (LAYOUT == fasd_pkg::LAY_UNIFORM)
      ? (1 << (ARRAY_AW - fasd_pkg::UNI_LSB))
      : (1 << (ARRAY_AW - fasd_pkg::S64_LSB)) - 2 + fasd_pkg::PSEC_CNT;

  logic [fasd_pkg::ADDR_W-1:0] eff_d;     // Next effective address
  logic [fasd_pkg::SECT_W-1:0] sector_d;  // Decoded sector index
  logic                        param_d;   // Decoded small-sector flag
  logic                        ext_q;     // Extended mode, from bar_q

  assign ext_q = bar_q[fasd_pkg::EXT_BIT];

  // Builds the effective address of one command
  function automatic logic [fasd_pkg::ADDR_W-1:0] compose(
    input logic [fasd_pkg::ADDR_W-1:0] a,
    input logic                        legacy,
    input logic                        main,
    input logic [fasd_pkg::BAR_W-1:0]  bar);
    logic [fasd_pkg::ADDR_W-1:0] r;
    r = a;
    // Other spaces always see all 32 bits
    if (main && legacy && !bar[fasd_pkg::EXT_BIT]) begin
      // Legacy 24-bit field, bank supplies the rest
      r = {1'b0, bar[fasd_pkg::BANK_W-1:0],
           a[fasd_pkg::LEG_AW-1:0]};
    end
    // Small part: main array only needs 24 bits
    if (main && SMALL) begin
      r[fasd_pkg::ADDR_W-1:fasd_pkg::LEG_AW] = '0;
    end
    compose = r;
  endfunction

  // Address forming; extended mode and new commands keep all bits, except that the small part clears 31..24 for the main array
  always_comb begin
    eff_d = compose(cmd_addr, cmd_legacy, cmd_main, bar_q);
  end

  // Sector lookup on the array part of the formed address
  fasd_sector_map #(
    .AW     (ARRAY_AW),
    .LAYOUT (LAYOUT)
  ) u_map (
    .addr   (eff_d[ARRAY_AW-1:0]),
    .sector (sector_d),
    .param  (param_d)
  );

  // Bank address register; a command in the same cycle sees the
  // old value, so a load only affects later commands
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bar_q <= fasd_pkg::BAR_RST;
    end else if (bar_wr) begin
      bar_q <= bar_wr_data;
    end
  end

  // Length the decoder must collect for a legacy command
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr32_q <= 1'b0;
    end else if (bar_wr) begin
      addr32_q <= bar_wr_data[fasd_pkg::EXT_BIT];
    end
  end

  // Result strobe, one cycle after the command
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_valid_q <= 1'b0;
    end else begin
      out_valid_q <= cmd_valid;
    end
  end

  // Result word, held until the next command
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      eff_addr_q <= 32'h0000_0000;
      main_q     <= 1'b0;
      sector_q   <= '0;
      param_q    <= 1'b0;
    end else if (cmd_valid) begin
      eff_addr_q <= eff_d;
      main_q     <= cmd_main;
      // Sector only means something in the main array
      sector_q   <= cmd_main ? sector_d : '0;
      param_q    <= cmd_main && param_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks; all on clk_sys, quiet while reset is high except the reset check
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // A bank load followed by a legacy 24-bit command
  sequence s_bank_load;
    bar_wr && !bar_wr_data[fasd_pkg::EXT_BIT] && !cmd_valid;
  endsequence

  sequence s_legacy_cmd;
    cmd_valid && cmd_legacy && cmd_main;
  endsequence

  // Reset leaves bank zero and 24-bit mode
  a_reset_bank_clear: assert property (
    disable iff (1'b0)
    reset |=> (bar_q == fasd_pkg::BAR_RST) && !addr32_q)
    else $error("bank register not cleared by reset");

  // Loaded bank shows up in the next legacy address
  a_bank_high_bits: assert property (
    s_bank_load ##1 s_legacy_cmd |=>
      eff_addr_q[fasd_pkg::LEG_AW-1:0] ==
        $past(cmd_addr[fasd_pkg::LEG_AW-1:0]) &&
      (SMALL || eff_addr_q[fasd_pkg::ADDR_W-1:fasd_pkg::LEG_AW] ==
        {1'b0, $past(bar_wr_data[fasd_pkg::BANK_W-1:0], 2)}))
    else $error("legacy address missing bank bits");

  // Extended mode: legacy command keeps host upper bits
  a_ext_full_addr: assert property (
    cmd_valid && cmd_legacy && cmd_main && ext_q && !SMALL |=>
      eff_addr_q == $past(cmd_addr))
    else $error("extended mode did not use 32-bit address");

  // Extended mode flag tracks the written bit
  a_ext_len_flag: assert property (
    bar_wr |=> addr32_q == $past(bar_wr_data[fasd_pkg::EXT_BIT])
      && ext_q == addr32_q)
    else $error("address length flag out of step");

  // New commands ignore the bank register
  a_new_cmd_full: assert property (
    cmd_valid && !cmd_legacy && cmd_main && !SMALL |=>
      eff_addr_q == $past(cmd_addr))
    else $error("new command address altered");

  // Small part clears the top byte for the array
  a_small_top_zero: assert property (
    cmd_valid && cmd_main && SMALL |=>
      eff_addr_q[fasd_pkg::ADDR_W-1:fasd_pkg::LEG_AW] == '0)
    else $error("upper address byte not dropped");

  // Other spaces pass the address untouched
  a_space_passthru: assert property (
    cmd_valid && !cmd_main |=>
      eff_addr_q == $past(cmd_addr) && !param_q && sector_q == '0)
    else $error("separate space address altered");

  // One result strobe per command, next cycle only
  a_result_timing: assert property (
    cmd_valid && !$past(cmd_valid) |=> out_valid_q ##1
      (out_valid_q == $past(cmd_valid)))
    else $error("result strobe not one cycle after command");

  // Bottom layout: small sectors exactly below 128 kB
  a_bottom_map: assert property (
    out_valid_q && main_q && LAYOUT == fasd_pkg::LAY_BOTTOM |->
      param_q == (eff_addr_q[ARRAY_AW-1:fasd_pkg::PREG_LSB] == '0)
      && (!param_q || sector_q ==
        fasd_pkg::SECT_W'(eff_addr_q[16:fasd_pkg::PSEC_LSB])))
    else $error("bottom layout decode wrong");

  // Top layout: small sectors exactly in the top 128 kB
  a_top_map: assert property (
    out_valid_q && main_q && LAYOUT == fasd_pkg::LAY_TOP |->
      param_q == (&eff_addr_q[ARRAY_AW-1:fasd_pkg::PREG_LSB]) &&
      (param_q || sector_q == fasd_pkg::SECT_W'(
        eff_addr_q[ARRAY_AW-1:fasd_pkg::S64_LSB])))
    else $error("top layout decode wrong");

  // Uniform layout: 256 kB blocks, never a small sector
  a_uniform_map: assert property (
    out_valid_q && main_q && LAYOUT == fasd_pkg::LAY_UNIFORM |->
      !param_q && sector_q == fasd_pkg::SECT_W'(
        eff_addr_q[ARRAY_AW-1:fasd_pkg::UNI_LSB]))
    else $error("uniform layout decode wrong");

  // Index stays inside this model's sector count
  a_sector_bound: assert property (
    out_valid_q && main_q |->
      int'(sector_q) < NSECT)
    else $error("sector index beyond array");

  // A cycle with no command, and one with no bank load
  sequence s_no_cmd;
    !cmd_valid;
  endsequence

  sequence s_no_load;
    !bar_wr;
  endsequence

  // Legacy main-array command that takes its bank from the register
  sequence s_bank_path;
    cmd_valid && cmd_legacy && cmd_main && !ext_q;
  endsequence

  // Legacy command uses the bank held before its own cycle, so a
  // load in the same cycle must not leak into it
  a_bank_old_value: assert property (
    s_bank_path |=>
      eff_addr_q[fasd_pkg::LEG_AW-1:0] ==
        $past(cmd_addr[fasd_pkg::LEG_AW-1:0]) &&
      eff_addr_q[fasd_pkg::ADDR_W-1:fasd_pkg::LEG_AW] == (SMALL ? 8'h00 :
        {1'b0, $past(bar_q[fasd_pkg::BANK_W-1:0])}))
    else $error("legacy address used wrong bank value");

  // Bank register takes all eight written bits
  a_bank_load: assert property (
    bar_wr |=> bar_q == $past(bar_wr_data))
    else $error("bank register did not take written value");

  // Bank register and length flag change only on a load
  a_bank_hold: assert property (
    s_no_load |=> $stable(bar_q) && $stable(addr32_q))
    else $error("bank register changed without a load");

  // No result strobe without a command the cycle before
  a_no_stray_strobe: assert property (
    s_no_cmd |=> !out_valid_q)
    else $error("result strobe without a command");

  // Result word stands until the next command
  a_result_held: assert property (
    s_no_cmd |=> $stable(eff_addr_q) && $stable(main_q) &&
      $stable(sector_q) && $stable(param_q))
    else $error("result word changed without a command");

  // Small sectors exist only in the main array of hybrid layouts
  a_param_layout: assert property (
    param_q |-> main_q && LAYOUT != fasd_pkg::LAY_UNIFORM)
    else $error("small sector flag outside a hybrid layout");

  // Small sectors take the lowest or the highest indices
  a_param_index: assert property (
    out_valid_q && param_q |->
      ((LAYOUT == fasd_pkg::LAY_BOTTOM) ?
        (int'(sector_q) < fasd_pkg::PSEC_CNT) :
        (int'(sector_q) >= NSECT - fasd_pkg::PSEC_CNT)))
    else $error("small sector index out of place");

  // Bottom layout: 64 kB sectors numbered on after the small ones
  a_bottom_large: assert property (
    out_valid_q && main_q && !param_q &&
      LAYOUT == fasd_pkg::LAY_BOTTOM |->
      int'(sector_q) == int'(eff_addr_q[ARRAY_AW-1:fasd_pkg::S64_LSB])
        + fasd_pkg::PSEC_CNT - 2)
    else $error("bottom layout large sector index wrong");

  // Top layout: small sectors numbered on after the 64 kB ones
  a_top_small: assert property (
    out_valid_q && main_q && param_q &&
      LAYOUT == fasd_pkg::LAY_TOP |->
      int'(sector_q) == NSECT - fasd_pkg::PSEC_CNT +
        int'(eff_addr_q[fasd_pkg::PREG_LSB-1:fasd_pkg::PSEC_LSB]))
    else $error("top layout small sector index wrong");

endmodule
